// ### design/rss_pkg.sv
// Constants shared by the reset status sequencer.
// Assumes clock_i is the reference oscillator at 100 MHz.
// Notes on behaviour
// - Power-on low drops both status outputs at once
// - MCU status released 6120 periods after power-on
// - Main status released 9195 periods after power-on
// - Software MCU warm reset holds MCU status 966
// - Software resets hold main status low 4040
// - MCU warm drops MCU now, main after 960ns
// - MCU warm release: MCU 966, main 4040 periods
// - Warm request drops main after 900 isolation times
// - Warm request release holds main 4040 periods
// - Boot pins sampled at main power-on rise
// - Main power-on out: low 1200ns, release 1840ns later
`default_nettype none

package rss_pkg;
  // ----------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;     // Reference period
  localparam int unsigned CNT_W         = 16;     // Timer width
  localparam int unsigned MCU_POR_PER   = 6120;   // Periods after power-on
  localparam int unsigned MAIN_POR_PER  = 9195;   // Periods after power-on
  localparam int unsigned MCU_WARM_PER  = 966;    // Periods after warm
  localparam int unsigned MAIN_WARM_PER = 4040;   // Periods after warm
  localparam int unsigned ISO_MULT      = 900;    // Isolation multiplier
  localparam int unsigned MAIN_DLY_NS   = 960;    // Main drop after MCU warm
  localparam int unsigned POR_REL_NS    = 1840;   // Power-on out release
  localparam int unsigned POR_LOW_NS    = 1200;   // Power-on out low width
  // Least times round up
  localparam int unsigned MAIN_DLY_CYC  = (MAIN_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_REL_CYC   = (POR_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_LOW_CYC   = (POR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------
  localparam int unsigned STRAP_W   = 2;          // Debug straps
  localparam int unsigned BOOT_W    = 16;         // Boot pins
  localparam int unsigned SYNC_W    = 5;          // Synchronised inputs
  localparam logic [15:0] BOOT_RST  = 16'h0000;   // Boot latch reset
  localparam logic [1:0]  STRAP_RST = 2'h0;       // Strap latch reset
endpackage : rss_pkg

`default_nettype wire

// ### design/rss_sync.sv
// Two-flop synchroniser for the asynchronous reset pins.
// Assumes one clock; first stage is read only by the second.
`default_nettype none

module rss_sync #(
  parameter int unsigned WIDTH = 1,               // Bits synchronised
  parameter logic [WIDTH-1:0] RST_VAL = '0        // Value held in reset
) (
  input  wire logic             clock_i,          // Reference clock
  input  wire logic             resetn_i,         // Async reset, low
  input  wire logic [WIDTH-1:0] async_i,          // Raw pins
  output logic      [WIDTH-1:0] sync_o            // Synchronised pins
);
  // ----------------------------------------------------------
  // Stages
  // ----------------------------------------------------------
  logic [WIDTH-1:0] meta_q;                       // Metastable stage

  // Both stages in one process, first feeds second only
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : rss_sync

`default_nettype wire

// ### design/rss_timer.sv
// Down counter: reloads while load_i, busy while nonzero.
// Assumes load values fit the configured width.
`default_nettype none

module rss_timer #(
  parameter int unsigned W = 16                   // Counter width
) (
  input  wire logic         clock_i,              // Reference clock
  input  wire logic         resetn_i,             // Async reset, low
  input  wire logic         load_i,               // Reload request
  input  wire logic [W-1:0] value_i,              // Reload value
  output logic              busy_o                // Count nonzero
);
  // ----------------------------------------------------------
  // Counter
  // ----------------------------------------------------------
  logic [W-1:0] cnt_q;                            // Remaining periods

  // Load wins over counting so a held cause keeps it full
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy_o = (cnt_q != '0);

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_timer_load;
    @(posedge clock_i) disable iff (!resetn_i)
      load_i |=> (cnt_q == $past(value_i));
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("timer load lost");
endmodule : rss_timer

`default_nettype wire

// ### design/rss_top.sv
// Reset status sequencer: drives MCU and main status outputs,
// main power-on output, and latches straps and boot pins.
// Assumes clock_i is the reference oscillator and runs in reset.
`default_nettype none

module rss_top #(
  parameter int unsigned MCU_POR_CYC  = rss_pkg::MCU_POR_PER,  // Cycles
  parameter int unsigned MAIN_POR_CYC = rss_pkg::MAIN_POR_PER, // Cycles
  parameter int unsigned ISO_CYC      = 1                      // Isolation time, cycles
) (
  input  wire logic                        clock_i,               // Reference clock
  input  wire logic                        resetn_i,              // Async reset, low
  input  wire logic                        por_in_n_i,            // Power-on reset pin
  input  wire logic                        mcu_warm_rst_in_n_i,   // MCU warm pin
  input  wire logic                        main_warm_req_n_i,     // Main warm request
  input  wire logic                        sw_mcu_warm_i,         // Software MCU warm pulse
  input  wire logic                        sw_main_poweron_i,     // Software main power-on
  input  wire logic                        sw_main_warm_i,        // Software main warm
  input  wire logic [rss_pkg::STRAP_W-1:0] debug_strap_i,         // Debug strap pins
  input  wire logic [rss_pkg::BOOT_W-1:0]  boot_cfg_pins_i,       // Boot pins
  output logic                             mcu_rst_status_n_o,    // MCU status, low
  output logic                             main_rst_status_n_o,   // Main status, low
  output logic                             main_por_out_n_o,      // Main power-on, low
  output logic      [rss_pkg::STRAP_W-1:0] debug_strap_o,         // Latched straps
  output logic      [rss_pkg::BOOT_W-1:0]  boot_cfg_o             // Latched boot pins
);
  localparam int unsigned W = rss_pkg::CNT_W;

  // ----------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------
  logic [rss_pkg::SYNC_W-1:0] sync_s;             // Synchronised pins
  logic                       por_s;              // Power-on, high = released
  logic                       warm_s;             // MCU warm, high = released
  logic                       req_s;              // Warm request released
  logic [rss_pkg::STRAP_W-1:0] strap_s;           // Straps aligned with por_s

  // Straps ride with the power-on pin so they are sampled in step
  rss_sync #(
    .WIDTH   (rss_pkg::SYNC_W),
    .RST_VAL (5'h00)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .async_i  ({debug_strap_i, main_warm_req_n_i, mcu_warm_rst_in_n_i, por_in_n_i}),
    .sync_o   (sync_s)
  );

  assign por_s   = sync_s[0];
  assign warm_s  = sync_s[1];
  assign req_s   = sync_s[2];
  assign strap_s = sync_s[4:3];

  // ----------------------------------------------------------
  // Cause tracking
  // ----------------------------------------------------------
  logic mcu_por_q;                                // MCU release owed to power-on
  logic main_por_q;                               // Main release owed to power-on
  logic por_s_q;                                  // Power-on, one cycle late

  // Remember power-on cause until the output is released
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mcu_por_q  <= 1'b1;
      main_por_q <= 1'b1;
    end else begin
      if (!por_s) begin
        mcu_por_q <= 1'b1;
      end else if (mcu_rst_status_n_o) begin
        mcu_por_q <= 1'b0;
      end
      if (!por_s) begin
        main_por_q <= 1'b1;
      end else if (main_rst_status_n_o) begin
        main_por_q <= 1'b0;
      end
    end
  end

  // Delayed power-on level for strap edge detection
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_s_q <= 1'b0;
    end else begin
      por_s_q <= por_s;
    end
  end

  // ----------------------------------------------------------
  // MCU status
  // ----------------------------------------------------------
  logic         mcu_hold;                         // MCU held by pins
  logic         mcu_load;                         // Reload MCU timer
  logic [W-1:0] mcu_val;                          // MCU reload value
  logic         mcu_busy;                         // MCU timer running

  assign mcu_hold = !por_s || !warm_s;
  assign mcu_load = mcu_hold || sw_mcu_warm_i;
  // Power-on owes the MCU_POR_CYC count, warm causes the MCU_WARM_PER count
  assign mcu_val  = (mcu_por_q || !por_s) ? W'(MCU_POR_CYC)
                                          : W'(rss_pkg::MCU_WARM_PER);

  rss_timer #(
    .W (W)
  ) u_mcu_tmr (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .load_i   (mcu_load),
    .value_i  (mcu_val),
    .busy_o   (mcu_busy)
  );

  // Status stays low while held or counting
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mcu_rst_status_n_o <= 1'b0;
    end else begin
      mcu_rst_status_n_o <= !mcu_load && !mcu_busy;
    end
  end

  // ----------------------------------------------------------
  // Main drop delays
  // ----------------------------------------------------------
  logic warm_dly_busy;                            // MCU warm delay running
  logic req_dly_busy;                             // Request delay running
  logic main_drop;                                // Warm cause reached main

  // Delay armed while pin released, runs once pin falls
  rss_timer #(
    .W (W)
  ) u_warm_dly (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .load_i   (warm_s),
    .value_i  (W'(rss_pkg::MAIN_DLY_CYC)),
    .busy_o   (warm_dly_busy)
  );

  // Isolation delay scales with the ISO_CYC isolation-time parameter
  rss_timer #(
    .W (W)
  ) u_req_dly (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .load_i   (req_s),
    .value_i  (W'(rss_pkg::ISO_MULT * ISO_CYC)),
    .busy_o   (req_dly_busy)
  );

  assign main_drop = (!warm_s && !warm_dly_busy) || (!req_s && !req_dly_busy);

  // ----------------------------------------------------------
  // Main status
  // ----------------------------------------------------------
  logic         main_hold;                        // Main held by causes
  logic         sw_main_any;                      // Any software main cause
  logic         main_load;                        // Reload main timer
  logic [W-1:0] main_val;                         // Main reload value
  logic         main_busy;                        // Main timer running

  assign sw_main_any = sw_mcu_warm_i || sw_main_poweron_i || sw_main_warm_i;
  assign main_hold   = !por_s || main_drop;
  assign main_load   = main_hold || sw_main_any;
  assign main_val    = (main_por_q || !por_s) ? W'(MAIN_POR_CYC)
                                              : W'(rss_pkg::MAIN_WARM_PER);

  rss_timer #(
    .W (W)
  ) u_main_tmr (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .load_i   (main_load),
    .value_i  (main_val),
    .busy_o   (main_busy)
  );

  // Main status follows its timer
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      main_rst_status_n_o <= 1'b0;
    end else begin
      main_rst_status_n_o <= !main_load && !main_busy;
    end
  end

  // ----------------------------------------------------------
  // Main power-on output
  // ----------------------------------------------------------
  logic         por_load;                         // Reload power-on timer
  logic [W-1:0] por_val;                          // Power-on reload value
  logic         por_busy;                         // Power-on timer running
  logic         por_out_d;                        // Next power-on output

  // Pin hold makes the low width; software gets the fixed minimum
  assign por_load  = !por_s || sw_main_poweron_i;
  assign por_val   = !por_s ? W'(rss_pkg::POR_REL_CYC)
                            : W'(rss_pkg::POR_LOW_CYC);
  assign por_out_d = !por_load && !por_busy;

  rss_timer #(
    .W (W)
  ) u_por_tmr (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .load_i   (por_load),
    .value_i  (por_val),
    .busy_o   (por_busy)
  );

  // Power-on output flop
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      main_por_out_n_o <= 1'b0;
    end else begin
      main_por_out_n_o <= por_out_d;
    end
  end

  // ----------------------------------------------------------
  // Strap and boot latches
  // ----------------------------------------------------------
  // Boot pins caught on the edge where the output rises
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boot_cfg_o <= rss_pkg::BOOT_RST;
    end else if (por_out_d && !main_por_out_n_o) begin
      boot_cfg_o <= boot_cfg_pins_i;
    end
  end

  // Straps caught at the synchronised power-on release
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      debug_strap_o <= rss_pkg::STRAP_RST;
    end else if (por_s && !por_s_q) begin
      debug_strap_o <= strap_s;
    end
  end

  // ----------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------
  logic [W-1:0] por_hi_cnt;                       // Cycles power-on high
  logic [W-1:0] warm_hi_cnt;                      // Cycles MCU warm high
  logic [W-1:0] req_hi_cnt;                       // Cycles request high

  // Saturating run lengths of released pins
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_hi_cnt  <= '0;
      warm_hi_cnt <= '0;
      req_hi_cnt  <= '0;
    end else begin
      por_hi_cnt  <= !por_s ? '0 : (&por_hi_cnt ? por_hi_cnt : por_hi_cnt + W'(1));
      warm_hi_cnt <= !warm_s ? '0 : (&warm_hi_cnt ? warm_hi_cnt : warm_hi_cnt + W'(1));
      req_hi_cnt  <= !req_s ? '0 : (&req_hi_cnt ? req_hi_cnt : req_hi_cnt + W'(1));
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_por_mcu_low;
    !por_s |=> !mcu_rst_status_n_o;
  endproperty
  a_por_mcu_low: assert property (p_por_mcu_low) else $error("MCU status not low");

  property p_por_main_low;
    !por_s |=> !main_rst_status_n_o && !main_por_out_n_o;
  endproperty
  a_por_main_low: assert property (p_por_main_low) else $error("main not low");

  property p_mcu_por_rel;
    $rose(mcu_rst_status_n_o) |-> por_hi_cnt >= W'(MCU_POR_CYC);
  endproperty
  a_mcu_por_rel: assert property (p_mcu_por_rel) else $error("MCU released early");

  property p_main_por_rel;
    $rose(main_rst_status_n_o) |-> por_hi_cnt >= W'(MAIN_POR_CYC);
  endproperty
  a_main_por_rel: assert property (p_main_por_rel) else $error("main released early");

  // Warm figures bind only warm-caused releases; power-on counts may be shorter in tests
  property p_mcu_warm_rel;
    $rose(mcu_rst_status_n_o) && !mcu_por_q |-> warm_hi_cnt >= W'(rss_pkg::MCU_WARM_PER);
  endproperty
  a_mcu_warm_rel: assert property (p_mcu_warm_rel) else $error("MCU warm early");

  property p_main_warm_rel;
    $rose(main_rst_status_n_o) && !main_por_q |-> warm_hi_cnt >= W'(rss_pkg::MAIN_WARM_PER)
                                && req_hi_cnt >= W'(rss_pkg::MAIN_WARM_PER);
  endproperty
  a_main_warm_rel: assert property (p_main_warm_rel) else $error("main warm early");

  property p_warm_mcu;
    !warm_s |=> !mcu_rst_status_n_o;
  endproperty
  a_warm_mcu: assert property (p_warm_mcu) else $error("warm missed MCU");

  property p_sw_main;
    sw_main_any |=> !main_rst_status_n_o [*8];
  endproperty
  a_sw_main: assert property (p_sw_main) else $error("software main too short");

  property p_por_out_rel;
    $rose(main_por_out_n_o) |-> por_hi_cnt >= W'(rss_pkg::POR_REL_CYC);
  endproperty
  a_por_out_rel: assert property (p_por_out_rel) else $error("power-on out early");

  property p_boot_cap;
    $rose(main_por_out_n_o) |-> boot_cfg_o == $past(boot_cfg_pins_i);
  endproperty
  a_boot_cap: assert property (p_boot_cap) else $error("boot pins not caught");

  c_por_release: cover property ($rose(main_rst_status_n_o) && main_por_q);
  c_warm_cycle:  cover property (!warm_s ##1 warm_s ##[1:1000] $rose(mcu_rst_status_n_o));
  c_req_drop:    cover property (!req_s && $fell(main_rst_status_n_o));
  c_sw_poweron:  cover property (sw_main_poweron_i ##[1:300] $rose(main_por_out_n_o));
endmodule : rss_top

`default_nettype wire

// ### verif/rss_board_model.sv
// Board-side model: supervisor driving the reset pins, straps and boot pins.
// Assumes the bench calls its tasks; every pin changes at a falling edge.
`default_nettype none

module rss_board_model (
  input  wire logic                        clock_i,             // Reference clock
  output logic                             por_in_n_o,          // Power-on pin
  output logic                             mcu_warm_rst_in_n_o, // MCU warm pin
  output logic                             main_warm_req_n_o,   // Main warm request
  output logic      [rss_pkg::STRAP_W-1:0] debug_strap_o,       // Strap pins
  output logic      [rss_pkg::BOOT_W-1:0]  boot_cfg_pins_o      // Boot pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------
  // Pin state
  // ----------------------------------------------------------
  localparam time HOLD_NS = 1200;                 // Shortest low time of a reset pin
  logic [2:0]                  pin_q   = 3'h6;    // Power-on low at power-up
  time                         fall_t [3] = '{0, 0, 0}; // Time of last fall
  logic [rss_pkg::STRAP_W-1:0] strap_q = 2'h0;    // Strap level
  logic [rss_pkg::BOOT_W-1:0]  boot_q  = 16'h0000; // Boot level

  assign por_in_n_o          = pin_q[0];
  assign mcu_warm_rst_in_n_o = pin_q[1];
  assign main_warm_req_n_o   = pin_q[2];
  assign debug_strap_o       = strap_q;
  assign boot_cfg_pins_o     = boot_q;

  // ----------------------------------------------------------
  // Tasks used by the bench
  // ----------------------------------------------------------
  // Drive one reset pin; a short pulse would be lost in the synchroniser
  task automatic drive_pin(input int sel, input logic v);
    @(negedge clock_i);
    if (v) begin
      // Release waits out the minimum low time
      while ($time - fall_t[sel] < HOLD_NS) @(negedge clock_i);
    end else begin
      fall_t[sel] = $time;
    end
    pin_q[sel] = v;
  endtask

  // Straps and boot pins only move well clear of their sampling edges
  task automatic set_cfg(input logic [1:0] s, input logic [15:0] b);
    @(negedge clock_i);
    strap_q = s;
    boot_q  = b;
  endtask
endmodule // rss_board_model

`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the reset status sequencer.
// Assumes shortened power-on counts (60/90) and the board model beside it.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------
  // Clock, reset and wiring
  // ----------------------------------------------------------
  logic        clock_i  = 1'b0;  // 100 MHz reference
  logic        resetn_i = 1'b0;  // Held low at start
  logic [2:0]  sw_q     = 3'h0;  // Software pulses: mcu, poweron, warm
  wire         por_n, warm_n, req_n, mcu_st_n, main_st_n, por_out_n;
  wire  [1:0]  strap_pin, strap_lat;
  wire  [15:0] boot_pin, boot_lat;
  int          errors = 0;       // Mismatches
  int          checks = 0;       // Comparisons
  int          cycles = 0;       // Timeout counter

  always #5 clock_i = ~clock_i;

  rss_board_model board (.clock_i(clock_i), .por_in_n_o(por_n), .mcu_warm_rst_in_n_o(warm_n),
    .main_warm_req_n_o(req_n), .debug_strap_o(strap_pin), .boot_cfg_pins_o(boot_pin));

  rss_top #(.MCU_POR_CYC(60), .MAIN_POR_CYC(90), .ISO_CYC(1)) dut (.clock_i(clock_i),
    .resetn_i(resetn_i), .por_in_n_i(por_n), .mcu_warm_rst_in_n_i(warm_n),
    .main_warm_req_n_i(req_n), .sw_mcu_warm_i(sw_q[0]), .sw_main_poweron_i(sw_q[1]),
    .sw_main_warm_i(sw_q[2]), .debug_strap_i(strap_pin), .boot_cfg_pins_i(boot_pin),
    .mcu_rst_status_n_o(mcu_st_n), .main_rst_status_n_o(main_st_n),
    .main_por_out_n_o(por_out_n), .debug_strap_o(strap_lat), .boot_cfg_o(boot_lat));

  // ----------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------
  // Single value compare
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Output picked by number: 0 mcu status, 1 main status, 2 power-on out
  function automatic logic pick(input int sel);
    case (sel)
      0:       return mcu_st_n;
      1:       return main_st_n;
      default: return por_out_n;
    endcase
  endfunction

  // Count falling edges until an output reaches a level; n runs on across calls
  task automatic measure(input int sel, input logic lvl, input int lo, input int hi,
                         input string what, inout int n);
    while (pick(sel) !== lvl && n <= hi) begin
      @(negedge clock_i);
      n++;
    end
    checks++;
    if (n < lo || n > hi) begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d cycles seen %0d", what, lo, hi, n);
    end
  endtask

  // One-cycle software pulse
  task automatic sw_pulse(input int sel);
    @(negedge clock_i);
    sw_q[sel] = 1'b1;
    @(negedge clock_i);
    sw_q[sel] = 1'b0;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Power-up release: three outputs in order, straps and boot pins latched
  task automatic t_power_on();
    int n;
    n = 0;
    board.set_cfg(2'h2, 16'hA5C3);
    repeat (3) @(negedge clock_i);
    check("mcu status in power-on", 16'h0, {15'h0, mcu_st_n});
    check("main status in power-on", 16'h0, {15'h0, main_st_n});
    check("power-on out in power-on", 16'h0, {15'h0, por_out_n});
    board.drive_pin(0, 1'b1);
    measure(0, 1'b1, 60, 66, "mcu status release", n);
    measure(1, 1'b1, 90, 96, "main status release", n);
    measure(2, 1'b1, 184, 190, "power-on out release", n);
    check("straps latched", 16'h2, {14'h0, strap_lat});
    check("boot latched", 16'hA5C3, boot_lat);
    board.set_cfg(2'h1, 16'h3C5A);
    // Straps pass two sync stages and a latch, so wait past them
    repeat (4) @(negedge clock_i);
    check("straps held", 16'h2, {14'h0, strap_lat});
    check("boot held", 16'hA5C3, boot_lat);
  endtask

  // MCU warm pin: mcu drops at once, main only after 96 cycles
  task automatic t_mcu_warm();
    int n;
    n = 0;
    board.drive_pin(1, 1'b0);
    measure(0, 1'b0, 0, 4, "mcu status drop", n);
    measure(1, 1'b0, 96, 102, "main status drop", n);
    board.drive_pin(1, 1'b1);
    n = 0;
    measure(0, 1'b1, 966, 972, "mcu status warm release", n);
    measure(1, 1'b1, 4040, 4046, "main status warm release", n);
  endtask

  // Main warm request: 900 isolation cycles to drop, 4040 to release
  task automatic t_main_req();
    int n;
    n = 0;
    board.drive_pin(2, 1'b0);
    measure(1, 1'b0, 900, 906, "main status request drop", n);
    board.drive_pin(2, 1'b1);
    n = 0;
    measure(1, 1'b1, 4040, 4046, "main status request release", n);
  endtask

  // Software MCU warm reset drops both status outputs
  task automatic t_sw_mcu();
    int n;
    n = 0;
    sw_pulse(0);
    check("mcu status sw drop", 16'h0, {15'h0, mcu_st_n});
    check("main status sw drop", 16'h0, {15'h0, main_st_n});
    measure(0, 1'b1, 966, 972, "mcu status sw width", n);
    measure(1, 1'b1, 4040, 4046, "main status sw mcu width", n);
  endtask

  // Software main power-on: output pulse, new boot pins, main status width
  task automatic t_sw_poweron();
    int n;
    n = 0;
    sw_pulse(1);
    check("power-on out sw drop", 16'h0, {15'h0, por_out_n});
    measure(2, 1'b1, 120, 126, "power-on out sw width", n);
    check("boot relatched", 16'h3C5A, boot_lat);
    measure(1, 1'b1, 4040, 4046, "main status sw poweron width", n);
  endtask

  // Software main warm reset
  task automatic t_sw_warm();
    int n;
    n = 0;
    sw_pulse(2);
    check("main status sw warm drop", 16'h0, {15'h0, main_st_n});
    measure(1, 1'b1, 4040, 4046, "main status sw warm width", n);
  endtask

  // Power-on reapplied mid-run: all drop, power-on counts and strap latch return
  task automatic t_por_again();
    int n;
    n = 0;
    board.drive_pin(0, 1'b0);
    measure(0, 1'b0, 0, 4, "mcu status power-on drop", n);
    check("main status power-on drop", 16'h0, {15'h0, main_st_n});
    check("power-on out power-on drop", 16'h0, {15'h0, por_out_n});
    board.drive_pin(0, 1'b1);
    n = 0;
    measure(0, 1'b1, 60, 66, "mcu status power-on again", n);
    measure(1, 1'b1, 90, 96, "main status power-on again", n);
    measure(2, 1'b1, 184, 190, "power-on out again", n);
    check("straps relatched", 16'h1, {14'h0, strap_lat});
  endtask

  // ----------------------------------------------------------
  // Verdict, timeout and main sequence
  // ----------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole run needs about 22000 cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      $display("[FAIL] run length expected 40000 cycles seen %0d", cycles);
      conclude();
    end
  end

  initial begin
    repeat (5) @(negedge clock_i);
    resetn_i = 1'b1;
    t_power_on();
    t_mcu_warm();
    t_main_req();
    t_sw_mcu();
    t_sw_poweron();
    t_sw_warm();
    t_por_again();
    conclude();
  end
endmodule // testbench

`default_nettype wire
